/* include/ric_consts.svh */
// constants for the relay timing and input counter block
`ifndef RIC_CONSTS_SVH
`define RIC_CONSTS_SVH

// ==========================================
// sizes
`define RIC_NOUT          8
`define RIC_NIN           8
`define RIC_SECS_W        8
`define RIC_CNT_W         16
`define RIC_DIV_W         28

// ==========================================
// timing
`define RIC_CLK_PERIOD_NS  32'h0000_0005
// one second, in ns
`define RIC_TICK_PERIOD_NS 32'h3B9A_CA00

// ==========================================
// register byte offsets
`define RIC_OFF_CMD       8'h00
`define RIC_OFF_TOGGLE    8'h04
`define RIC_OFF_UNAVAIL   8'h08
`define RIC_OFF_INVERT    8'h0C
`define RIC_OFF_COIL      8'h10
`define RIC_OFF_LEVEL     8'h14
`define RIC_OFF_CNT_CLR   8'h18
`define RIC_OFF_REJECT    8'h1C
`define RIC_OFF_BUSY      8'h20
// per-channel windows, selected by paddr[7:5], channel in paddr[4:2]
`define RIC_WIN_CFG       3'h2
`define RIC_WIN_CNT       3'h3

// ==========================================
// config word fields
`define RIC_CFG_MODE_LSB  0
`define RIC_CFG_TON_LSB   8
`define RIC_CFG_TOFF_LSB  16

// ==========================================
// reset values
`define RIC_RST_MODE      2'h1
`define RIC_RST_SECS      8'h00

`endif

/* include/ric_pkg.sv */
// types for the relay timing and input counter block
`include "ric_consts.svh"

package ric_pkg;

  // ==========================================
  // output channel modes
  typedef enum logic [1:0] {
    RIC_MODE_DISABLE  = 2'h0,
    RIC_MODE_BISTABLE = 2'h1,
    RIC_MODE_ASTABLE  = 2'h2,
    RIC_MODE_ONEPULSE = 2'h3
  } ric_mode_e;

  // ==========================================
  // output channel timing states
  typedef enum logic [3:0] {
    RIC_OS_IDLE = 4'h1,
    RIC_OS_GAP  = 4'h2,
    RIC_OS_ON   = 4'h4,
    RIC_OS_HELD = 4'h8
  } ric_ost_e;

  typedef struct packed {
    logic [`RIC_SECS_W-1:0] toff;
    logic [`RIC_SECS_W-1:0] ton;
    ric_mode_e              mode;
  } ric_cfg_s;

  typedef struct packed {
    ric_ost_e               st;
    logic [`RIC_SECS_W-1:0] secs;
  } ric_och_s;

  // ==========================================
  // bus carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ric_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ric_apb_rsp_s;

  // ==========================================
  // module state
  typedef struct packed {
    logic [`RIC_NOUT-1:0]           cmd;
    logic [`RIC_NOUT-1:0]           unavail;
    logic [`RIC_NOUT-1:0]           inv;
    logic [`RIC_NOUT-1:0]           rej;
    logic [`RIC_NOUT-1:0]           coil;
    ric_cfg_s [`RIC_NOUT-1:0]       cfg;
    ric_och_s [`RIC_NOUT-1:0]       och;
    logic [`RIC_DIV_W-1:0]          div;
    logic                           tick;
    logic [31:0]                    rdata;
    logic                           err;
  } ric_core_s;

  typedef struct packed {
    logic [2:0]            sync;
    logic                  level;
    logic [`RIC_CNT_W-1:0] cnt;
  } ric_sense_s;

endpackage : ric_pkg

/* core/ric_sense_chan.sv */
// one sense input: pin synchroniser, level and activation counter
`timescale 1ns/1ps
`include "ric_consts.svh"

module ric_sense_chan (
  input  wire logic                  clk_i,    // system clock
  input  wire logic                  reset_i,  // sync reset, high
  input  wire logic                  pin_i,    // field contact, async
  input  wire logic                  clr_i,    // counter clear pulse
  output logic                       level_o,  // filtered level
  output logic [`RIC_CNT_W-1:0]      count_o   // activations since clear
);

  ric_pkg::ric_sense_s q_ff;
  ric_pkg::ric_sense_s nxt_q_ff;
  logic                rise;

  // ==========================================
  // next state
  always_comb begin
    nxt_q_ff = q_ff;
    rise = 1'b0;
    nxt_q_ff.sync = {q_ff.sync[1:0], pin_i};
    // new level only once stages two and three agree
    if (q_ff.sync[1] == q_ff.sync[2]) begin
      nxt_q_ff.level = q_ff.sync[2];
      rise = q_ff.sync[2] & ~q_ff.level;
    end
    // a rise in the clear cycle still counts
    if (clr_i) begin
      nxt_q_ff.cnt = {{(`RIC_CNT_W-1){1'b0}}, rise};
    end else if (rise) begin
      nxt_q_ff.cnt = q_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q_ff;
    end
  end

  assign level_o = q_ff.level;
  assign count_o = q_ff.cnt;

endmodule : ric_sense_chan

/* core/ric_core.sv */
// relay output timing and input activation counters, APB slave
//
// How it works
// - a disabled output rests at base level and ignores on/off commands.
// - cycle mode repeats on for high interval, off for low, while commanded.
// - single-shot waits low interval, drives on for high interval, releases.
// - invert swaps the resting level; coil is complement of plain behaviour.
// - interval settings only matter in cycle and single-shot modes.
// - commanded level and coil level are kept and reported separately.
// - cycle mode keeps commanded on while the coil alternates.
// - a manual toggle inverts the commanded level of that channel.
// - shutter or routed outputs are unavailable and refuse manual toggles.
// - each input reports its level and counts activations since clear.
// - per-channel clear zeroes only that input's counter.
//
// ==========================================
// register map, byte offsets
// 0x00 command levels, rw
// 0x04 toggle mask, write only, reads zero
// 0x08 unavailable mask, rw
// 0x0c invert mask, rw
// 0x10 coil levels, read only
// 0x14 input levels, read only
// 0x18 counter clear mask, write only
// 0x1c refused toggles, write one to clear
// 0x20 channels whose timing state is not idle, held included, read only
// 0x40 + 4 * ch channel config: mode, high and low seconds
// 0x60 + 4 * ch activation count, read only, wraps
// masks sit in bits 7:0, upper bits read zero
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "ric_consts.svh"

module ric_core #(
  parameter int TICK_CYCLES = `RIC_TICK_PERIOD_NS / `RIC_CLK_PERIOD_NS
) (
  input  wire logic                 clk_i,      // 200 MHz clock
  input  wire logic                 reset_i,    // sync reset, high
  input  ric_pkg::ric_apb_req_s     apb_req_i,  // APB request
  output ric_pkg::ric_apb_rsp_s     apb_rsp_o,  // APB response
  input  wire logic [`RIC_NIN-1:0]  sense_i,    // field contacts
  output logic [`RIC_NOUT-1:0]      coil_o,     // relay coil drive
  output logic [`RIC_NOUT-1:0]      cmd_o       // commanded levels
);

  // ==========================================
  // declarations
  ric_pkg::ric_core_s          q_ff;
  ric_pkg::ric_core_s          nxt_q_ff;
  logic [`RIC_NIN-1:0]         in_level;
  logic [`RIC_CNT_W-1:0]       in_cnt [`RIC_NIN];
  logic [`RIC_NIN-1:0]         cnt_clr;
  logic                        setup;
  logic                        wr;
  logic [7:0]                  addr;
  logic [31:0]                 wdata;
  logic [2:0]                  idx;
  logic [2:0]                  win;
  logic                        hit;
  logic [31:0]                 rd;
  logic [`RIC_NOUT-1:0]        tog;
  logic [`RIC_NOUT-1:0]        rej_clr;
  logic [`RIC_NOUT-1:0]        busy;
  logic [`RIC_NOUT-1:0]        cmd_nxt;
  logic [`RIC_NOUT-1:0]        timed;
  logic [`RIC_NOUT-1:0]        coil_plain;
  logic [`RIC_NOUT-1:0]        tog_ok;
  logic [`RIC_NOUT-1:0]        tog_bad;

  assign addr  = apb_req_i.paddr;
  assign wdata = apb_req_i.pwdata;
  assign idx   = addr[4:2];
  assign win   = addr[7:5];
  assign setup = apb_req_i.psel & ~apb_req_i.penable;
  // zero wait states: access phase always completes
  assign wr    = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;

  // ==========================================
  // input channels
  // counters live in the channel modules; clear is a one-cycle strobe
  generate
    for (genvar g = 0; g < `RIC_NIN; g++) begin : g_sense
      ric_sense_chan u_sense (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (sense_i[g]),
        .clr_i   (cnt_clr[g]),
        .level_o (in_level[g]),
        .count_o (in_cnt[g])
      );
    end
  endgenerate

  always_comb begin
    cnt_clr = '0;
    if (wr && addr == `RIC_OFF_CNT_CLR) begin
      cnt_clr = wdata[`RIC_NIN-1:0];
    end
  end

  // ==========================================
  // channel activity, for the busy register
  always_comb begin
    busy = '0;
    for (int i = 0; i < `RIC_NOUT; i++) begin
      busy[i] = q_ff.och[i].st != ric_pkg::RIC_OS_IDLE;
    end
  end

  // ==========================================
  // modes that run the interval machine
  // intervals stay stored in untimed modes but are never read there
  always_comb begin
    timed = '0;
    for (int i = 0; i < `RIC_NOUT; i++) begin
      timed[i] = q_ff.cfg[i].mode == ric_pkg::RIC_MODE_ASTABLE ||
                 q_ff.cfg[i].mode == ric_pkg::RIC_MODE_ONEPULSE;
    end
  end

  // ==========================================
  // coil drive before inversion
  always_comb begin
    coil_plain = '0;
    for (int i = 0; i < `RIC_NOUT; i++) begin
      unique case (q_ff.cfg[i].mode)
        ric_pkg::RIC_MODE_DISABLE: begin
          coil_plain[i] = 1'b0;
        end
        ric_pkg::RIC_MODE_BISTABLE: begin
          coil_plain[i] = q_ff.cmd[i];
        end
        ric_pkg::RIC_MODE_ASTABLE,
        ric_pkg::RIC_MODE_ONEPULSE: begin
          coil_plain[i] = q_ff.och[i].st == ric_pkg::RIC_OS_ON;
        end
      endcase
    end
  end

  // ==========================================
  // read decode, sampled in the setup cycle
  always_comb begin
    rd  = 32'h0000_0000;
    hit = 1'b1;
    if (win == `RIC_WIN_CFG) begin
      rd[`RIC_CFG_MODE_LSB +: 2] = q_ff.cfg[idx].mode;
      rd[`RIC_CFG_TON_LSB +: `RIC_SECS_W] = q_ff.cfg[idx].ton;
      rd[`RIC_CFG_TOFF_LSB +: `RIC_SECS_W] = q_ff.cfg[idx].toff;
    end else if (win == `RIC_WIN_CNT) begin
      rd[`RIC_CNT_W-1:0] = in_cnt[idx];
    end else begin
      case (addr)
        `RIC_OFF_CMD: begin
          rd[`RIC_NOUT-1:0] = q_ff.cmd;
        end
        `RIC_OFF_TOGGLE: begin
          rd = 32'h0000_0000;
        end
        `RIC_OFF_UNAVAIL: begin
          rd[`RIC_NOUT-1:0] = q_ff.unavail;
        end
        `RIC_OFF_INVERT: begin
          rd[`RIC_NOUT-1:0] = q_ff.inv;
        end
        `RIC_OFF_COIL: begin
          rd[`RIC_NOUT-1:0] = q_ff.coil;
        end
        `RIC_OFF_LEVEL: begin
          rd[`RIC_NIN-1:0] = in_level;
        end
        `RIC_OFF_CNT_CLR: begin
          rd = 32'h0000_0000;
        end
        `RIC_OFF_REJECT: begin
          rd[`RIC_NOUT-1:0] = q_ff.rej;
        end
        `RIC_OFF_BUSY: begin
          rd[`RIC_NOUT-1:0] = busy;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // toggle requests and rejected-toggle flags
  always_comb begin
    tog     = '0;
    rej_clr = '0;
    if (wr && addr == `RIC_OFF_TOGGLE) begin
      tog = wdata[`RIC_NOUT-1:0];
    end
    if (wr && addr == `RIC_OFF_REJECT) begin
      rej_clr = wdata[`RIC_NOUT-1:0];
    end
  end

  // split requests into accepted and refused channels
  assign tog_ok  = tog & ~q_ff.unavail;
  assign tog_bad = tog & q_ff.unavail;

  // ==========================================
  // next state
  always_comb begin
    nxt_q_ff = q_ff;
    cmd_nxt  = q_ff.cmd;

    // one-second tick
    // one shared divider is cheaper than one per channel, at the cost
    // of up to one second of jitter at the start of an interval
    nxt_q_ff.tick = 1'b0;
    if (q_ff.div == `RIC_DIV_W'(TICK_CYCLES - 1)) begin
      nxt_q_ff.div  = '0;
      nxt_q_ff.tick = 1'b1;
    end else begin
      nxt_q_ff.div = q_ff.div + 28'h000_0001;
    end

    // read data and error latched in setup, shown in access
    if (setup) begin
      nxt_q_ff.rdata = rd;
      nxt_q_ff.err   = ~hit;
    end

    // register writes
    if (wr) begin
      if (win == `RIC_WIN_CFG) begin
        nxt_q_ff.cfg[idx].mode =
          ric_pkg::ric_mode_e'(wdata[`RIC_CFG_MODE_LSB +: 2]);
        nxt_q_ff.cfg[idx].ton  = wdata[`RIC_CFG_TON_LSB +: `RIC_SECS_W];
        nxt_q_ff.cfg[idx].toff = wdata[`RIC_CFG_TOFF_LSB +: `RIC_SECS_W];
      end else begin
        case (addr)
          `RIC_OFF_CMD: begin
            cmd_nxt = wdata[`RIC_NOUT-1:0];
          end
          `RIC_OFF_UNAVAIL: begin
            nxt_q_ff.unavail = wdata[`RIC_NOUT-1:0];
          end
          `RIC_OFF_INVERT: begin
            nxt_q_ff.inv = wdata[`RIC_NOUT-1:0];
          end
          default: begin
          end
        endcase
      end
    end

    // manual toggle, refused on unavailable channels
    cmd_nxt = cmd_nxt ^ tog_ok;
    nxt_q_ff.cmd = cmd_nxt;
    // a new refusal wins over a clear in the same cycle
    nxt_q_ff.rej = (q_ff.rej & ~rej_clr) | tog_bad;
    nxt_q_ff.coil = coil_plain ^ q_ff.inv;

    // per-channel timing
    // idle: waiting for a command in a timed mode
    // gap: low interval running, coil released
    // on: high interval running, coil driven
    // held: single shot spent, waits for the command to drop
    // the tick free-runs, so the first second of an interval may be
    // short by up to one tick; a zero interval passes in one cycle
    for (int i = 0; i < `RIC_NOUT; i++) begin
      unique case (q_ff.och[i].st)
        ric_pkg::RIC_OS_IDLE: begin
          if (q_ff.cmd[i] && q_ff.cfg[i].mode == ric_pkg::RIC_MODE_ASTABLE) begin
            nxt_q_ff.och[i].st   = ric_pkg::RIC_OS_ON;
            nxt_q_ff.och[i].secs = q_ff.cfg[i].ton;
          end else if (q_ff.cmd[i] &&
                       q_ff.cfg[i].mode == ric_pkg::RIC_MODE_ONEPULSE) begin
            nxt_q_ff.och[i].st   = ric_pkg::RIC_OS_GAP;
            nxt_q_ff.och[i].secs = q_ff.cfg[i].toff;
          end
        end
        ric_pkg::RIC_OS_GAP: begin
          if (!q_ff.cmd[i]) begin
            nxt_q_ff.och[i].st = ric_pkg::RIC_OS_IDLE;
          end else if (q_ff.och[i].secs == `RIC_RST_SECS) begin
            nxt_q_ff.och[i].st   = ric_pkg::RIC_OS_ON;
            nxt_q_ff.och[i].secs = q_ff.cfg[i].ton;
          end else if (q_ff.tick) begin
            nxt_q_ff.och[i].secs = q_ff.och[i].secs - 8'h01;
          end
        end
        ric_pkg::RIC_OS_ON: begin
          if (!q_ff.cmd[i]) begin
            nxt_q_ff.och[i].st = ric_pkg::RIC_OS_IDLE;
          end else if (q_ff.och[i].secs == `RIC_RST_SECS) begin
            if (q_ff.cfg[i].mode == ric_pkg::RIC_MODE_ASTABLE) begin
              nxt_q_ff.och[i].st   = ric_pkg::RIC_OS_GAP;
              nxt_q_ff.och[i].secs = q_ff.cfg[i].toff;
            end else begin
              nxt_q_ff.och[i].st = ric_pkg::RIC_OS_HELD;
            end
          end else if (q_ff.tick) begin
            nxt_q_ff.och[i].secs = q_ff.och[i].secs - 8'h01;
          end
        end
        ric_pkg::RIC_OS_HELD: begin
          // single shot done; rearm only after the command drops
          if (!q_ff.cmd[i]) begin
            nxt_q_ff.och[i].st = ric_pkg::RIC_OS_IDLE;
          end
        end
        default: begin
          nxt_q_ff.och[i].st = ric_pkg::RIC_OS_IDLE;
        end
      endcase

      // untimed modes never run the interval machine
      if (!timed[i]) begin
        nxt_q_ff.och[i].st   = ric_pkg::RIC_OS_IDLE;
        nxt_q_ff.och[i].secs = `RIC_RST_SECS;
      end
    end
  end

  // ==========================================
  // state register
  // every channel comes up bistable and idle with its coil released
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_ff <= '0;
      for (int i = 0; i < `RIC_NOUT; i++) begin
        q_ff.cfg[i].mode <= ric_pkg::ric_mode_e'(`RIC_RST_MODE);
        q_ff.och[i].st   <= ric_pkg::RIC_OS_IDLE;
      end
    end else begin
      q_ff <= nxt_q_ff;
    end
  end

  // ==========================================
  // outputs
  // no wait states: every register answers from flops or the decode
  // error only shows in the access phase, so a stray setup stays quiet
  assign coil_o            = q_ff.coil;
  assign cmd_o             = q_ff.cmd;
  assign apb_rsp_o.pready  = 1'b1;
  assign apb_rsp_o.pslverr = q_ff.err & apb_req_i.psel & apb_req_i.penable;
  assign apb_rsp_o.prdata  = q_ff.rdata;

endmodule : ric_core

/* test/ric_core_props.sv */
// checker for the relay timing and input counter core
`timescale 1ns/1ps
`include "ric_consts.svh"

module ric_core_props #(
  parameter int TICK_CYCLES = 10
) (
  input  wire logic                 clk_i,      // clock
  input  wire logic                 reset_i,    // sync reset
  input  ric_pkg::ric_apb_req_s     apb_req_i,  // apb request
  input  ric_pkg::ric_apb_rsp_s     apb_rsp_o,  // apb response
  input  wire logic [`RIC_NIN-1:0]  sense_i,    // contacts
  input  wire logic [`RIC_NOUT-1:0] coil_o,     // coil drive
  input  wire logic [`RIC_NOUT-1:0] cmd_o       // commanded levels
);
  // ==========
  // shadows of bus-written config, so masks know which mode a bit is in
  logic [7:0]  unav_ff;
  logic [7:0]  inv_ff;
  logic [15:0] mode_ff;
  logic [7:0]  dis_d_ff;
  logic [7:0]  bis_d_ff;
  logic [7:0]  dis;
  logic [7:0]  bis;
  logic        wr;

  assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dis[i] = mode_ff[2*i +: 2] == 2'h0;
      bis[i] = mode_ff[2*i +: 2] == 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      unav_ff  <= 8'h00;
      inv_ff   <= 8'h00;
      mode_ff  <= 16'h5555;
      dis_d_ff <= 8'h00;
      bis_d_ff <= 8'hff;
    end else begin
      dis_d_ff <= dis;
      bis_d_ff <= bis;
      if (wr && apb_req_i.paddr == 8'h08) begin
        unav_ff <= apb_req_i.pwdata[7:0];
      end
      if (wr && apb_req_i.paddr == 8'h0C) begin
        inv_ff <= apb_req_i.pwdata[7:0];
      end
      if (wr && apb_req_i.paddr[7:5] == 3'h2) begin
        mode_ff[{apb_req_i.paddr[4:2], 1'b0} +: 2] <= apb_req_i.pwdata[1:0];
      end
    end
  end

  // ==========
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence wr_at(logic [7:0] a);
    wr && apb_req_i.paddr == a;
  endsequence
  sequence apb_setup;
    apb_req_i.psel && !apb_req_i.penable;
  endsequence

  cmd_write_a: assert property (wr_at(8'h00) |=> cmd_o == $past(apb_req_i.pwdata[7:0]))
    else $error("command write not taken");
  toggle_flip_a: assert property (wr_at(8'h04) |=> cmd_o == $past(cmd_o ^ (apb_req_i.pwdata[7:0] & ~unav_ff)))
    else $error("toggle did not invert available channels");
  toggle_reject_a: assert property (wr_at(8'h04) |=> ((cmd_o ^ $past(cmd_o)) & $past(unav_ff)) == 8'h00)
    else $error("unavailable channel toggled");
  cmd_hold_a: assert property (!(wr && apb_req_i.paddr[7:3] == 5'h00) |=> $stable(cmd_o))
    else $error("commanded level moved without a command");
  reset_quiet_a: assert property ($fell(reset_i) |-> coil_o == 8'h00 && cmd_o == 8'h00)
    else $error("outputs not at rest after reset");
  disabled_rest_a: assert property (((coil_o ^ $past(inv_ff)) & dis & dis_d_ff) == 8'h00)
    else $error("disabled output left its resting level");
  bistable_follow_a: assert property (((coil_o ^ $past(cmd_o ^ inv_ff)) & bis & bis_d_ff) == 8'h00)
    else $error("coil not command xor invert");
  apb_ready_a: assert property (apb_setup |=> apb_rsp_o.pready)
    else $error("access phase without ready");
endmodule : ric_core_props

bind ric_core ric_core_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .clk_i(clk_i), .reset_i(reset_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o),
  .sense_i(sense_i), .coil_o(coil_o), .cmd_o(cmd_o));

/* test/ric_field_model.sv */
// field contact model driving the sense inputs
`timescale 1ns/1ps

module ric_field_model (
  input  wire logic clk_i,    // clock
  output logic [7:0] sense_o  // contact levels
);
  // ==========
  // clean contacts; hold sets prompt or slow change
  initial sense_o = 8'h00;

  task automatic press(input int ch, input logic lv, input int hold);
    @(posedge clk_i);
    sense_o[ch] <= lv;
    repeat (hold) @(posedge clk_i);
  endtask : press
endmodule : ric_field_model

/* test/ric_core_test.sv */
// self-checking bench for the relay timing and input counter core
`timescale 1ns/1ps
`include "ric_consts.svh"

module ric_core_test;
  localparam int TICK = 10;
  logic                  clk_i;
  logic                  reset_i;
  ric_pkg::ric_apb_req_s apb_req;
  ric_pkg::ric_apb_rsp_s apb_rsp;
  logic [7:0]            sense;
  logic [7:0]            coil;
  logic [7:0]            cmd;
  logic [31:0]           rnd;
  logic [31:0]           q;
  logic                  err;
  logic [7:0]            ecmd;
  logic [7:0]            ton;
  logic [7:0]            toff;
  logic [15:0]           ecnt [8];
  int                    miscompares;
  int                    num_checks;
  int                    n;
  int                    ch;
  int                    h;

  ric_core #(.TICK_CYCLES(TICK)) dut (.clk_i(clk_i), .reset_i(reset_i), .apb_req_i(apb_req),
    .apb_rsp_o(apb_rsp), .sense_i(sense), .coil_o(coil), .cmd_o(cmd));
  ric_field_model field (.clk_i(clk_i), .sense_o(sense));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // partial first second allowed, so a window not an exact count
  function automatic logic in_win(input int len, input logic [7:0] secs);
    int s;
    s = secs;
    return len >= (s - 1) * TICK + 1 && len <= s * TICK + 3;
  endfunction : in_win

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    apb_req.penable <= 1'b1;
    @(posedge clk_i);
    while (apb_rsp.pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge clk_i);
    end
    if (k == 20) begin
      miscompares++;
      tally_and_finish();
    end
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic run(input int c, input logic lv, output int len);
    len = 0;
    while (coil[c] === lv && len < 200) begin
      len++;
      @(posedge clk_i);
    end
  endtask : run

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #100_000;
    miscompares++;
    tally_and_finish();
  end

  // ==========
  // main sequence
  initial begin
    reset_i = 1'b1;
    apb_req = '0;
    rnd = 32'habed_fff5;
    miscompares = 0;
    num_checks = 0;
    for (int i = 0; i < 8; i++) ecnt[i] = 16'h0000;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    check({cmd, coil}, 32'h0000_0000);
    rd(8'h44);
    check(q, 32'h0000_0001);
    rd(8'h3C);
    check({31'h0, err}, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr(8'h00, rnd);
      wr(8'h0C, {24'h0, rnd[15:8]});
      ecmd = rnd[7:0];
      rd(8'h00);
      check(q, {24'h0, ecmd});
      check({24'h0, coil}, {24'h0, ecmd ^ rnd[15:8]});
      rd(8'h10);
      check(q, {24'h0, ecmd ^ rnd[15:8]});
      wr(8'h08, {24'h0, rnd[23:16]});
      rd(8'h08);
      check(q, {24'h0, rnd[23:16]});
      wr(8'h1C, 32'h0000_00ff);
      wr(8'h04, {24'h0, rnd[31:24]});
      ecmd = ecmd ^ (rnd[31:24] & ~rnd[23:16]);
      rd(8'h00);
      check(q, {24'h0, ecmd});
      rd(8'h1C);
      check(q, {24'h0, rnd[31:24] & rnd[23:16]});
    end
    wr(8'h0C, 32'h0000_0000);
    wr(8'h40, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    @(posedge clk_i);
    check({cmd[0], coil[0]}, 32'h0000_0002);
    wr(8'h0C, 32'h0000_0001);
    rd(8'h00);
    check({31'h0, coil[0]}, 32'h0000_0001);
    wr(8'h0C, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      ton = {6'h0, rnd[1:0]} % 8'h03 + 8'h01;
      toff = {6'h0, rnd[3:2]} % 8'h03 + 8'h01;
      wr(8'h00, 32'h0000_0000);
      wr(8'h44, {8'h0, toff, ton, 8'h02});
      wr(8'h48, {8'h0, toff, ton, 8'h03});
      wr(8'h00, 32'h0000_0002);
      run(1, 1'b0, n);
      run(1, 1'b1, n);
      check({31'h0, in_win(n, ton)}, 32'h0000_0001);
      run(1, 1'b0, n);
      check({31'h0, in_win(n, toff)}, 32'h0000_0001);
      check({31'h0, cmd[1]}, 32'h0000_0001);
      wr(8'h00, 32'h0000_0006);
      run(2, 1'b0, n);
      check({31'h0, in_win(n, toff)}, 32'h0000_0001);
      run(2, 1'b1, n);
      check({31'h0, in_win(n, ton)}, 32'h0000_0001);
      run(2, 1'b0, n);
      check(n, 200);
      rd(8'h20);
      check(q, 32'h0000_0006);
      wr(8'h44, {8'h0, toff, ton, 8'h01});
      rd(8'h00);
      run(1, 1'b1, n);
      check(n, 200);
    end
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      ch = rnd[2:0];
      h = 5 + rnd[7:5];
      for (int j = 0; j <= rnd[9:8]; j++) begin
        field.press(ch, 1'b1, h);
        ecnt[ch]++;
        rd(8'h14);
        check(q, 32'h1 << ch);
        field.press(ch, 1'b0, h);
      end
      for (int c = 0; c < 8; c++) begin
        rd(8'h60 + 8'(4 * c));
        check(q, {16'h0, ecnt[c]});
      end
    end
    field.press(ch, 1'b1, 6);
    wr(8'h18, 32'h1 << ch);
    ecnt[ch] = 16'h0000;
    rd(8'h14);
    check(q, 32'h1 << ch);
    field.press(ch, 1'b0, 6);
    for (int c = 0; c < 8; c++) begin
      rd(8'h60 + 8'(4 * c));
      check(q, {16'h0, ecnt[c]});
    end
    tally_and_finish();
  end
endmodule : ric_core_test
